// >>> design/frame_bitblt_pkg.sv
// Package with the constants and types of the frame bitBLT order engine.
package frame_bitblt_pkg;

	// ----------------------------------------------------------------
	// Order opcodes, lengths and field offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  OP_SRC_DST      = 8'h12;
	localparam logic [7:0]  OP_SRC_TILE_DST = 8'h13;
	localparam logic [7:0]  OP_SCALED       = 8'h16;
	localparam logic [7:0]  RESERVED_BYTE   = 8'h00;
	localparam logic [4:0]  LEN_SD          = 5'h0e;
	localparam logic [4:0]  LEN_SHD         = 5'h16;
	localparam logic [4:0]  LEN_XD          = 5'h12;
	localparam int          HDR_BYTES       = 22;
	localparam int          F_DST           = 2;
	localparam int          F_FW            = 6;
	localparam int          F_FH            = 8;
	localparam int          F_SRC           = 10;
	localparam int          F_HXR           = 14;
	localparam int          F_HYR           = 16;
	localparam int          F_HA            = 18;
	localparam int          F_SW            = 14;
	localparam int          F_XB            = 16;
	localparam int          F_YB            = 17;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0]  A_CTRL          = 8'h00;
	localparam logic [7:0]  A_STATUS        = 8'h04;
	localparam logic [7:0]  A_ORDER_ADDR    = 8'h08;
	localparam logic [7:0]  A_LOGIC         = 8'h0c;
	localparam logic [7:0]  A_SRC_STRIDE    = 8'h10;
	localparam logic [7:0]  A_TILE_DIM      = 8'h14;
	localparam logic [7:0]  A_ORDER_COUNT   = 8'h18;
	localparam logic [7:0]  A_CUR_ADDR      = 8'h1c;
	localparam int          ST_BUSY         = 0;
	localparam int          ST_DONE         = 1;
	localparam int          ST_BAD_OP       = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  RST_SD_CODE     = 4'hc;
	localparam logic [7:0]  RST_STD_CODE    = 8'hf0;
	localparam logic [31:0] RST_WORD        = 32'h0000_0000;
	// Set bit n when an x_scale_code of n is supported.
	localparam logic [15:0] X_SCALE_OK      = 16'hffff;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;

	typedef enum logic [8:0] {
		S_IDLE   = 9'b0_0000_0001,
		S_FETCH  = 9'b0_0000_0010,
		S_DECODE = 9'b0_0000_0100,
		S_SRC    = 9'b0_0000_1000,
		S_TILE   = 9'b0_0001_0000,
		S_DST    = 9'b0_0010_0000,
		S_WR     = 9'b0_0100_0000,
		S_STEP   = 9'b0_1000_0000,
		S_NEXT   = 9'b1_0000_0000
	} state_e;

endpackage : frame_bitblt_pkg

// >>> design/frame_bitblt_order_engine.sv
// Frame bitBLT order engine with AXI4-Lite registers and a memory port.
`timescale 1ns/1ps

module frame_bitblt_order_engine
	import frame_bitblt_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             mem_req,
	output logic             mem_we,
	output logic [31:0]      mem_addr,
	output logic [31:0]      mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] be32(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c, input logic [7:0] d);
		be32 = {a, b, c, d};
	endfunction : be32

	// Pixels are packed MSB first; a bit address picks a word and a bit.
	function automatic logic [31:0] word_of(input logic [31:0] bit_addr);
		word_of = {3'b000, bit_addr[31:5], 2'b00};
	endfunction : word_of

	function automatic logic pick(input logic [31:0] w, input logic [31:0] ba);
		pick = w[~ba[4:0]];
	endfunction : pick

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// ----------------------------------------------------------------
	// Register file and AXI4-Lite slave
	// ----------------------------------------------------------------
	logic        aw_got, next_aw_got, w_got, next_w_got;
	logic [7:0]  aw_q, next_aw_q;
	logic [31:0] wd_q, next_wd_q;
	logic [3:0]  ws_q, next_ws_q;
	logic        next_bvalid, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [31:0] order_addr, next_order_addr, src_stride, next_src_stride;
	logic [31:0] tile_dim, next_tile_dim, order_count, next_order_count;
	logic [31:0] logic_reg, next_logic_reg;
	logic        done_flag, next_done_flag, bad_flag, next_bad_flag;
	logic        start;
	logic        busy;
	logic        set_done, set_bad;
	logic [31:0] order_ptr;
	logic [31:0] wr_val;
	logic [3:0]  sd_code;
	logic [7:0]  std_code;
	logic [15:0] tile_w, tile_h;

	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready  = !w_got && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign sd_code  = logic_reg[3:0];
	assign std_code = logic_reg[15:8];
	assign tile_w   = tile_dim[15:0];
	assign tile_h   = tile_dim[31:16];

	always_comb begin
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_q = aw_q;
		next_wd_q = wd_q;
		next_ws_q = ws_q;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rresp = s_axi_rresp;
		next_rdata = s_axi_rdata;
		next_order_addr = order_addr;
		next_src_stride = src_stride;
		next_tile_dim = tile_dim;
		next_order_count = order_count;
		next_logic_reg = logic_reg;
		next_done_flag = done_flag;
		next_bad_flag = bad_flag;
		start = 1'b0;
		wr_val = RST_WORD;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_got = 1'b1;
			next_aw_q = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_got = 1'b1;
			next_wd_q = s_axi_wdata;
			next_ws_q = s_axi_wstrb;
		end
		if (aw_got && w_got && !s_axi_bvalid) begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			wr_val = merge(RST_WORD, wd_q, ws_q);
			unique case (aw_q)
				A_CTRL: start = wr_val[0] && !busy;
				A_STATUS: begin
					next_done_flag = done_flag && !wr_val[ST_DONE];
					next_bad_flag = bad_flag && !wr_val[ST_BAD_OP];
				end
				A_ORDER_ADDR: next_order_addr = merge(order_addr, wd_q, ws_q);
				A_LOGIC: next_logic_reg = merge(logic_reg, wd_q, ws_q) &
					32'h0000_ff0f;
				A_SRC_STRIDE: next_src_stride = merge(src_stride, wd_q, ws_q);
				A_TILE_DIM: next_tile_dim = merge(tile_dim, wd_q, ws_q);
				A_ORDER_COUNT: next_order_count = merge(order_count, wd_q, ws_q);
				A_CUR_ADDR: ;
				default: next_bresp = RESP_SLVERR;
			endcase
		end
		// Hardware events win over a clear in the same cycle.
		if (set_done) begin
			next_done_flag = 1'b1;
		end
		if (set_bad) begin
			next_bad_flag = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				A_CTRL: next_rdata = RST_WORD;
				A_STATUS: next_rdata = {29'h0000_0000, bad_flag, done_flag, busy};
				A_ORDER_ADDR: next_rdata = order_addr;
				A_LOGIC: next_rdata = logic_reg;
				A_SRC_STRIDE: next_rdata = src_stride;
				A_TILE_DIM: next_rdata = tile_dim;
				A_ORDER_COUNT: next_rdata = order_count;
				A_CUR_ADDR: next_rdata = order_ptr;
				default: begin
					next_rdata = RST_WORD;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_q <= A_CTRL;
			wd_q <= RST_WORD;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= RST_WORD;
			order_addr <= RST_WORD;
			src_stride <= RST_WORD;
			tile_dim <= RST_WORD;
			order_count <= RST_WORD;
			logic_reg <= {16'h0000, RST_STD_CODE, 4'h0, RST_SD_CODE};
			done_flag <= 1'b0;
			bad_flag <= 1'b0;
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_q <= next_aw_q;
			wd_q <= next_wd_q;
			ws_q <= next_ws_q;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			order_addr <= next_order_addr;
			src_stride <= next_src_stride;
			tile_dim <= next_tile_dim;
			order_count <= next_order_count;
			logic_reg <= next_logic_reg;
			done_flag <= next_done_flag;
			bad_flag <= next_bad_flag;
		end
	end

	// ----------------------------------------------------------------
	// Order engine
	// ----------------------------------------------------------------
	state_e      state, next_state;
	logic [7:0]  hdr [HDR_BYTES], next_hdr [HDR_BYTES];
	logic [4:0]  idx, next_idx, olen, next_olen;
	logic [7:0]  op, next_op;
	logic [31:0] next_order_ptr, orders_left, next_orders_left;
	logic [15:0] fw, next_fw, fh, next_fh, xc, next_xc, yc, next_yc;
	logic [31:0] dst_row, next_dst_row, dst_cur, next_dst_cur;
	logic [31:0] src_row, next_src_row, src_cur, next_src_cur, sstep, next_sstep;
	logic [31:0] t_row, next_t_row, t_cur, next_t_cur;
	logic [15:0] t_cols, next_t_cols, t_rows, next_t_rows, tile_cols_left, next_hxr;
	logic [3:0]  xm, next_xm, ym, next_ym, xclip, next_xclip, px, next_px;
	logic [3:0]  py, next_py;
	logic        s_bit, next_s_bit, t_bit, next_t_bit, res, dst_old;
	logic        next_mem_req, next_mem_we, done_acc;
	logic [31:0] next_mem_addr, next_mem_wdata, tile_area;
	logic [1:0]  bsel;

	assign busy = (state != S_IDLE);
	assign done_acc = mem_req && mem_ack;
	assign tile_area = tile_w * tile_h;
	assign bsel = order_ptr[1:0] + idx[1:0];
	// The old destination bit is taken from the word held in mem_wdata; it
	// is passed by argument so the result follows every change of that word.
	assign dst_old = pick(mem_wdata, dst_cur);
	assign res = (op == OP_SRC_TILE_DST) ? std_code[{s_bit, t_bit, dst_old}]
		: sd_code[{s_bit, dst_old}];

	always_comb begin
		next_state = state;
		next_hdr = hdr;
		next_idx = idx;
		next_olen = olen;
		next_op = op;
		next_order_ptr = order_ptr;
		next_orders_left = orders_left;
		next_fw = fw;
		next_fh = fh;
		next_xc = xc;
		next_yc = yc;
		next_dst_row = dst_row;
		next_dst_cur = dst_cur;
		next_src_row = src_row;
		next_src_cur = src_cur;
		next_sstep = sstep;
		next_t_row = t_row;
		next_t_cur = t_cur;
		next_t_cols = t_cols;
		next_t_rows = t_rows;
		next_hxr = tile_cols_left;
		next_xm = xm;
		next_ym = ym;
		next_xclip = xclip;
		next_px = px;
		next_py = py;
		next_s_bit = s_bit;
		next_t_bit = t_bit;
		next_mem_req = mem_req && !mem_ack;
		next_mem_we = mem_we;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		set_done = 1'b0;
		set_bad = 1'b0;
		unique case (state)
			S_IDLE: if (start) begin
				next_order_ptr = order_addr;
				next_orders_left = order_count;
				next_idx = 5'h00;
				next_olen = 5'h01;
				next_state = (order_count == RST_WORD) ? S_NEXT : S_FETCH;
			end
			S_FETCH: if (!mem_req) begin
				next_mem_req = 1'b1;
				next_mem_we = 1'b0;
				next_mem_addr = {order_ptr[31:2] + 30'(({1'b0, order_ptr[1:0]}
					+ {1'b0, idx}) >> 2), 2'b00};
			end else if (done_acc) begin
				// Byte 0 of a word sits in its top bits: fields are big-endian.
				next_hdr[idx] = mem_rdata[8*(3 - int'(bsel)) +: 8];
				next_idx = idx + 5'h01;
				if (idx == 5'h00) begin
					next_op = next_hdr[0];
					unique case (next_hdr[0])
						OP_SRC_DST: next_olen = LEN_SD;
						OP_SRC_TILE_DST: next_olen = LEN_SHD;
						OP_SCALED: next_olen = LEN_XD;
						default: begin
							set_bad = 1'b1;
							next_state = S_IDLE;
						end
					endcase
				end else if (next_idx == olen) begin
					next_state = S_DECODE;
				end
			end
			S_DECODE: begin
				next_fw = {hdr[F_FW], hdr[F_FW+1]};
				next_fh = {hdr[F_FH], hdr[F_FH+1]};
				next_dst_row = be32(hdr[F_DST], hdr[F_DST+1], hdr[F_DST+2],
					hdr[F_DST+3]);
				next_src_row = be32(hdr[F_SRC], hdr[F_SRC+1], hdr[F_SRC+2],
					hdr[F_SRC+3]);
				next_dst_cur = next_dst_row;
				next_src_cur = next_src_row;
				next_sstep = (src_stride != RST_WORD) ? src_stride
					: {16'h0000, next_fw};
				next_xm = 4'h0;
				next_ym = 4'h0;
				next_xclip = 4'h0;
				next_py = 4'h0;
				if (op == OP_SCALED) begin
					next_sstep = {16'h0000, hdr[F_SW], hdr[F_SW+1]};
					next_ym = hdr[F_YB][3:0];
					next_py = hdr[F_YB][7:4];
					if (X_SCALE_OK[hdr[F_XB][3:0]]) begin
						next_xm = hdr[F_XB][3:0];
						next_xclip = hdr[F_XB][7:4];
					end
				end
				next_px = next_xclip;
				next_hxr = {hdr[F_HXR], hdr[F_HXR+1]};
				next_t_cols = next_hxr;
				next_t_rows = {hdr[F_HYR], hdr[F_HYR+1]};
				next_t_row = be32(hdr[F_HA], hdr[F_HA+1], hdr[F_HA+2],
					hdr[F_HA+3]);
				next_t_cur = next_t_row;
				next_xc = 16'h0000;
				next_yc = 16'h0000;
				next_state = (next_fw == 16'h0000 || next_fh == 16'h0000)
					? S_NEXT : S_SRC;
			end
			S_SRC: if (!mem_req) begin
				next_mem_req = 1'b1;
				next_mem_we = 1'b0;
				next_mem_addr = word_of(src_cur);
			end else if (done_acc) begin
				next_s_bit = pick(mem_rdata, src_cur);
				next_state = (op == OP_SRC_TILE_DST) ? S_TILE : S_DST;
			end
			S_TILE: if (!mem_req) begin
				next_mem_req = 1'b1;
				next_mem_addr = word_of(t_cur);
			end else if (done_acc) begin
				next_t_bit = pick(mem_rdata, t_cur);
				next_state = S_DST;
			end
			S_DST: if (!mem_req) begin
				next_mem_req = 1'b1;
				next_mem_addr = word_of(dst_cur);
			end else if (done_acc) begin
				next_mem_wdata = mem_rdata;
				next_state = S_WR;
			end
			S_WR: if (!mem_req) begin
				next_mem_req = 1'b1;
				next_mem_we = 1'b1;
				next_mem_wdata[~dst_cur[4:0]] = res;
			end else if (done_acc) begin
				next_mem_we = 1'b0;
				next_state = S_STEP;
			end
			S_STEP: begin
				next_state = S_SRC;
				if (xc != fw - 16'h0001) begin
					next_xc = xc + 16'h0001;
					next_dst_cur = dst_cur + 32'h0000_0001;
					if (px == xm) begin
						next_px = 4'h0;
						next_src_cur = src_cur + 32'h0000_0001;
					end else begin
						next_px = px + 4'h1;
					end
					if (t_cols == 16'h0001) begin
						next_t_cols = tile_w;
						next_t_cur = t_cur + 32'h0000_0001 - {16'h0000, tile_w};
					end else begin
						next_t_cols = t_cols - 16'h0001;
						next_t_cur = t_cur + 32'h0000_0001;
					end
				end else if (yc == fh - 16'h0001) begin
					next_state = S_NEXT;
				end else begin
					next_xc = 16'h0000;
					next_yc = yc + 16'h0001;
					next_dst_row = dst_row + {16'h0000, fw};
					next_dst_cur = next_dst_row;
					next_px = xclip;
					if (py == ym) begin
						next_py = 4'h0;
						next_src_row = src_row + sstep;
					end else begin
						next_py = py + 4'h1;
					end
					next_src_cur = next_src_row;
					// The tile is packed, so one tile row is tile_w bits.
					if (t_rows == 16'h0001) begin
						next_t_rows = tile_h;
						next_t_row = t_row + {16'h0000, tile_w} - tile_area;
					end else begin
						next_t_rows = t_rows - 16'h0001;
						next_t_row = t_row + {16'h0000, tile_w};
					end
					next_t_cur = next_t_row;
					next_t_cols = tile_cols_left;
				end
			end
			S_NEXT: begin
				next_order_ptr = order_ptr + {27'h000_0000, olen};
				next_orders_left = orders_left - 32'h0000_0001;
				next_idx = 5'h00;
				next_olen = 5'h01;
				if (orders_left <= 32'h0000_0001) begin
					set_done = 1'b1;
					next_state = S_IDLE;
				end else begin
					next_state = S_FETCH;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= S_IDLE;
			for (int i = 0; i < HDR_BYTES; i++) begin
				hdr[i] <= RESERVED_BYTE;
			end
			idx <= 5'h00;
			olen <= 5'h01;
			op <= RESERVED_BYTE;
			order_ptr <= RST_WORD;
			orders_left <= RST_WORD;
			fw <= 16'h0000;
			fh <= 16'h0000;
			xc <= 16'h0000;
			yc <= 16'h0000;
			dst_row <= RST_WORD;
			dst_cur <= RST_WORD;
			src_row <= RST_WORD;
			src_cur <= RST_WORD;
			sstep <= RST_WORD;
			t_row <= RST_WORD;
			t_cur <= RST_WORD;
			t_cols <= 16'h0000;
			t_rows <= 16'h0000;
			tile_cols_left <= 16'h0000;
			xm <= 4'h0;
			ym <= 4'h0;
			xclip <= 4'h0;
			px <= 4'h0;
			py <= 4'h0;
			s_bit <= 1'b0;
			t_bit <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= RST_WORD;
			mem_wdata <= RST_WORD;
		end else begin
			state <= next_state;
			hdr <= next_hdr;
			idx <= next_idx;
			olen <= next_olen;
			op <= next_op;
			order_ptr <= next_order_ptr;
			orders_left <= next_orders_left;
			fw <= next_fw;
			fh <= next_fh;
			xc <= next_xc;
			yc <= next_yc;
			dst_row <= next_dst_row;
			dst_cur <= next_dst_cur;
			src_row <= next_src_row;
			src_cur <= next_src_cur;
			sstep <= next_sstep;
			t_row <= next_t_row;
			t_cur <= next_t_cur;
			t_cols <= next_t_cols;
			t_rows <= next_t_rows;
			tile_cols_left <= next_hxr;
			xm <= next_xm;
			ym <= next_ym;
			xclip <= next_xclip;
			px <= next_px;
			py <= next_py;
			s_bit <= next_s_bit;
			t_bit <= next_t_bit;
			mem_req <= next_mem_req;
			mem_we <= next_mem_we;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
		end
	end

endmodule : frame_bitblt_order_engine

// >>> dv/frame_bitblt_order_engine_monitor.sv
// Port checker for the frame bitBLT order engine.
`timescale 1ns/1ps
module frame_bitblt_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic        mem_ack
);
	logic [31:0] rd_addr;
	logic [31:0] rd_data;

	// The last word read is the destination word that a write must rework.
	always_ff @(posedge aclk) begin
		if (mem_req && mem_ack && !mem_we) begin
			rd_addr <= mem_addr;
			rd_data <= mem_rdata;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_resp;
		##1 !s_axi_bvalid ##1 s_axi_bvalid;
	endsequence

	a_b_latency: assert property (s_wr_both |-> s_resp)
		else $error("write response late or early");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	a_b_refuse: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write taken early");
	a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req &&
		$stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
		else $error("memory request changed before answer");
	a_mem_drop: assert property (mem_req && mem_ack |=> !mem_req)
		else $error("memory request not released");
	a_mem_align: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
		else $error("memory address not word aligned");
	a_rmw_addr: assert property (mem_req && mem_we |-> mem_addr == rd_addr)
		else $error("write not to the word last read");
	a_rmw_bit: assert property (mem_req && mem_we |->
		$countones(mem_wdata ^ rd_data) <= 1) else $error("write alters bits");
endmodule : frame_bitblt_monitor

bind frame_bitblt_order_engine frame_bitblt_monitor u_mon (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
	.mem_ack);

// >>> dv/frame_bitblt_mem_model.sv
// Word memory that answers the engine's memory port.
`timescale 1ns/1ps
module frame_bitblt_mem_model (
	input wire logic        aclk,
	input wire logic [3:0]  dly,
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0]     mem_rdata,
	output logic            mem_ack
);
	logic [31:0] mem [256];
	logic [3:0]  wait_cnt = 4'h0;

	initial mem_ack = 1'b0;
	initial mem_rdata = 32'h0000_0000;
	// Read data toggles outside a read answer, so stale data never looks valid.
	always @(posedge aclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!mem_req || mem_ack) begin
			wait_cnt <= dly;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else begin
			mem_ack <= 1'b1;
			if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
			else mem_rdata <= mem[mem_addr[9:2]];
		end
	end
endmodule : frame_bitblt_mem_model

// >>> dv/tb_frame_bitblt_order_engine.sv
// Self-checking bench for the frame bitBLT order engine.
`timescale 1ns/1ps
module tb_frame_bitblt_order_engine
	import frame_bitblt_pkg::*;
;
	localparam int D1 = 515, S1 = 1285, D2 = 1921, T = 2560;
	localparam int D3 = 3207, S3 = 3840;
	logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, mem_req, mem_we, mem_ack;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [3:0]  s_axi_wstrb = 4'hf, dly = 0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] rv, em [256];
	int          n_fail = 0, total_checks = 0, seed = 32'hc997_2288;

	always #20 aclk = ~aclk;
	frame_bitblt_order_engine u_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req,
		.mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
	frame_bitblt_mem_model u_mem (.aclk, .dly, .mem_req, .mem_we, .mem_addr,
		.mem_wdata, .mem_rdata, .mem_ack);

	task automatic chk(logic [31:0] got, logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	task automatic tmo(int n, int lim);
		if (n >= lim) begin
			n_fail++;
			$display("Error at %0t: timeout", $time);
			end_sim();
		end
	endtask : tmo
	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		tmo(n, 20);
		chk(s_axi_bresp, r);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(logic [7:0] a);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		tmo(n, 20);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task automatic wait_idle(logic [31:0] e);
		int n;
		for (n = 0; n < 3000; n++) begin
			rd(A_STATUS);
			if (rv[ST_BUSY] === 1'b0) break;
		end
		tmo(n, 3000);
		chk(rv, e);
	endtask : wait_idle
	function automatic logic gb(int b);
		return em[b >> 5][31 - b % 32];
	endfunction : gb
	// Writes an order's fields big-endian, a zero width skips the field.
	function automatic void ord(int a, int v[9], int w[9]);
		for (int i = 0; i < 9; i++) begin
			for (int k = 0; k < w[i]; k++) begin
				em[a >> 2][31 - 8 * (a % 4) -: 8] = 8'(v[i] >> 8 * (w[i] - 1 - k));
				a++;
			end
		end
	endfunction : ord

	// ----------------------------------------------------------------
	// Three orders in one list, checked against a bit-level model
	// ----------------------------------------------------------------
	task automatic run(int st, logic [3:0] dl);
		int sd, td, p;
		logic s, t;
		sd = $random(seed);
		td = $random(seed);
		dly <= dl;
		foreach (em[i]) em[i] = $random(seed);
		ord(0, '{'h12, 0, D1, 7, 3, S1, 0, 0, 0}, '{1, 1, 4, 2, 2, 4, 0, 0, 0});
		ord(14, '{'h13, 0, D2, 7, 3, S1, 2, 1, T + 13}, '{1, 1, 4, 2, 2, 4, 2, 2, 4});
		ord(36, '{'h16, 0, D3, 7, 3, S3, 9, 'h12, 'h11}, '{1, 1, 4, 2, 2, 4, 2, 1, 1});
		foreach (em[i]) u_mem.mem[i] = em[i];
		wr(A_LOGIC, {16'h0000, td[7:0], 4'h0, sd[3:0]}, RESP_OKAY);
		wr(A_SRC_STRIDE, st, RESP_OKAY);
		wr(A_TILE_DIM, 32'h0003_0005, RESP_OKAY);
		wr(A_ORDER_ADDR, 32'h0000_0000, RESP_OKAY);
		wr(A_ORDER_COUNT, 32'h0000_0003, RESP_OKAY);
		wr(A_CTRL, 32'h0000_0001, RESP_OKAY);
		for (int y = 0; y < 3; y++) begin
			for (int x = 0; x < 7; x++) begin
				s = gb(S1 + y * (st != 0 ? st : 7) + x);
				p = D1 + y * 7 + x;
				em[p >> 5][31 - p % 32] = sd[{s, gb(p)}];
				t = gb(T + ((2 + y) % 3) * 5 + (3 + x) % 5);
				p = D2 + y * 7 + x;
				em[p >> 5][31 - p % 32] = td[{s, t, gb(p)}];
				s = gb(S3 + ((y + 1) / 2) * 9 + (x + 1) / 3);
				p = D3 + y * 7 + x;
				em[p >> 5][31 - p % 32] = sd[{s, gb(p)}];
			end
		end
		wait_idle(32'h0000_0002);
		// The pointer ends just past the third order: 14 + 22 + 18 bytes.
		rd(A_CUR_ADDR);
		chk(rv, 32'h0000_0036);
		chk(rr, RESP_OKAY);
		foreach (em[i]) chk(u_mem.mem[i], em[i]);
		wr(A_STATUS, 32'h0000_0007, RESP_OKAY);
		$display("order list done, stored stride %0d", st);
	endtask : run

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(A_LOGIC);
		chk(rv, 32'h0000_f00c);
		rd(8'h20);
		chk({rv[29:0], rr}, {30'h0, RESP_SLVERR});
		wr(8'h20, 32'h0000_0001, RESP_SLVERR);
		$display("register test done");
		run(0, 4'h0);
		run(24, 4'h3);
		u_mem.mem[0][31:24] = 8'h55;
		wr(A_ORDER_COUNT, 32'h0000_0001, RESP_OKAY);
		wr(A_CTRL, 32'h0000_0001, RESP_OKAY);
		wait_idle(32'h0000_0004);
		$display("bad opcode test done");
		end_sim();
	end
endmodule : tb_frame_bitblt_order_engine
